// *** rtl/output_terminal_function_select.sv ***
// Output terminal function selector with polarity, delay and register port
//
// Summary of operation
// - High-speed terminal: 0 pulse, 1 switch mode
// - Each terminal has own code 0..40
// - Reset codes: relay one 2, collector 1
// - Code 0 keeps terminal inactive
// - Code 3: active on fault stop
// - Code 4: motor overload pre-warning active
// - Code 5: active 10 s before overload
// - Code 6: zero frequency running, off stopped
// - Code 7: zero frequency, on when stopped
// - Code 8: upper frequency limit reached
// - Code 9: lower limit, off when stopped
// - Codes 10/11: set or designated count reached
// - Code 12: actual length above setpoint
// - Code 13: 250 ms pulse per cycle
// - Code 14: running time above threshold
// - Code 15: set frequency beyond limit, reached
// - Code 16: torque limit with stall protection
// - Code 17: circuits stable, no fault, ready
// - Code 18: drive running, zero included
// - Code 19: first analog above second
// - Code 20: undervoltage state
// - Per-terminal polarity digit inverts sense
// - Programmable output delay, 0.1 s steps
`timescale 1ns/1ps

module output_terminal_function_select
  import output_select_pkg::*;
#(
  parameter int unsigned TICK_CYC  = TICK_CYCLES,   // Cycles per 0.1 s step
  parameter int unsigned PULSE_CYC = PULSE_CYCLES   // Cycles in the 250 ms pulse
) (
  input  wire logic              clock_in,                 // System clock
  input  wire logic              nrst_in,                  // Async reset, active low
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,              // Word index
  input  wire logic [DATA_W-1:0] reg_wdata_in,             // Write data
  input  wire logic              reg_wr_in,                // Write strobe
  input  wire logic              reg_rd_in,                // Read strobe
  output logic      [DATA_W-1:0] reg_rdata_out,            // Read data, one cycle later
  // Drive status conditions, same clock domain
  input  wire logic              running_in,               // Drive running
  input  wire logic              fault_stop_in,            // Stopped by a fault
  input  wire logic              freq_reached_in,          // Frequency reached
  input  wire logic              freq_level_detect_one_in, // Level detect one output
  input  wire logic              motor_overload_warn_in,   // Motor load over pre-warning
  input  wire logic              drive_overload_accum_in,  // Drive overload accumulating
  input  wire logic [15:0]       drive_overload_left_in,   // Steps left to protection
  input  wire logic              output_freq_zero_in,      // Output frequency is zero
  input  wire logic              at_upper_limit_in,        // Running at upper limit
  input  wire logic              at_lower_limit_in,        // Running at lower limit
  input  wire logic              set_freq_beyond_in,       // Set frequency beyond a limit
  input  wire logic              count_set_reached_in,     // Count hit set value
  input  wire logic              count_desig_reached_in,   // Count hit designated value
  input  wire logic [15:0]       length_actual_in,         // Detected length
  input  wire logic [15:0]       length_setpoint_in,       // Length setpoint
  input  wire logic              sequencer_cycle_done_in,  // Sequencer cycle done
  input  wire logic [15:0]       run_time_in,              // Accumulated running time
  input  wire logic [15:0]       run_time_limit_in,        // Running time threshold
  input  wire logic              speed_mode_in,            // Speed control mode
  input  wire logic              torque_at_limit_in,       // Torque at its limit
  input  wire logic              stall_protect_in,         // Stall protection active
  input  wire logic              circuits_stable_in,       // Main and control stable
  input  wire logic              ready_in,                 // Drive ready to run
  input  wire logic [15:0]       first_analog_input_in,    // First analog value
  input  wire logic [15:0]       second_analog_input_in,   // Second analog value
  input  wire logic              undervoltage_in,          // Undervoltage state
  // Terminal outputs
  output logic                   pulse_output_mode_out,    // High-speed pin in pulse mode
  output logic                   switch_output_out,        // High-speed pin, switch level
  output logic                   relay_one_out,            // Relay one coil
  output logic                   relay_two_out,            // Relay two coil
  output logic                   collector_output_out      // Open-collector transistor
);

  localparam int unsigned TICK_W  = $clog2(TICK_CYC + 1);
  localparam int unsigned PULSE_W = $clog2(PULSE_CYC + 1);

  // ---------------- Register storage ----------------
  logic                hs_mode_ff;               // High-speed terminal mode
  logic [DATA_W-1:0]   fn_ff     [TERM_N];       // Selection codes per terminal
  logic [TERM_N-1:0]   pol_ff;                   // Polarity digits
  logic [DATA_W-1:0]   dly_ff    [TERM_N];       // Delay in 0.1 s steps
  logic [DATA_W-1:0]   rdata_ff;                 // Read data register

  // ---------------- Datapath state ----------------
  logic [TICK_W-1:0]   tick_cnt_ff;              // Step divider
  logic                tick;                     // One-cycle 0.1 s enable
  logic                seq_done_d_ff;            // Edge memory of cycle done
  logic [PULSE_W-1:0]  pulse_cnt_ff;             // Cycle-complete pulse timer
  logic                cycle_pulse;              // Pulse active
  logic [CODE_N-1:0]   cond;                     // Condition per selection code
  logic [TERM_N-1:0]   raw;                      // Selected condition per terminal
  logic [TERM_N-1:0]   state_ff;                 // Delivered logical state
  logic [TERM_N-1:0]   pin_ff;                   // Pin drive after polarity
  logic [DATA_W-1:0]   hold_cnt_ff [TERM_N];     // Delay counter per terminal

  // ---------------- Address decode ----------------
  wire                 hit_mode   = (reg_addr_in == OFF_HS_MODE);
  wire                 hit_pol    = (reg_addr_in == OFF_POLARITY);
  wire                 hit_status = (reg_addr_in == OFF_STATUS);
  wire                 hit_fn     = (reg_addr_in >= OFF_FN_BASE) &&
                                    (reg_addr_in <  OFF_FN_BASE + 4'(TERM_N));
  wire                 hit_dly    = (reg_addr_in >= OFF_DELAY_BASE) &&
                                    (reg_addr_in <  OFF_DELAY_BASE + 4'(TERM_N));
  wire [ADDR_W-1:0]    fn_off     = reg_addr_in - OFF_FN_BASE;
  wire [ADDR_W-1:0]    dly_off    = reg_addr_in - OFF_DELAY_BASE;
  wire [1:0]           fn_idx     = fn_off[1:0];
  wire [1:0]           dly_idx    = dly_off[1:0];

  // Delay writes beyond the longest step count are clamped, not wrapped
  wire [DATA_W-1:0]    dly_wval   = (reg_wdata_in > DELAY_MAX_STEP) ?
                                    DELAY_MAX_STEP : reg_wdata_in;

  // Status word: pins in low nibble, delivered state, then raw selection
  wire [DATA_W-1:0]    status_word = {3'h0, hs_mode_ff, raw, state_ff, pin_ff};

  // Read mux; unmapped addresses read as zero
  wire [DATA_W-1:0]    rd_value =
    hit_mode   ? {{(DATA_W-1){1'b0}}, hs_mode_ff} :
    hit_fn     ? fn_ff[fn_idx] :
    hit_pol    ? {{(DATA_W-TERM_N){1'b0}}, pol_ff} :
    hit_dly    ? dly_ff[dly_idx] :
    hit_status ? status_word :
                 {DATA_W{1'b0}};

  // Mode, polarity and read data registers
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hs_mode_ff <= RST_HS_MODE[0];
      pol_ff     <= RST_POLARITY[TERM_N-1:0];
      rdata_ff   <= 16'h0000;
    end else begin
      if (reg_wr_in && hit_mode) begin
        hs_mode_ff <= reg_wdata_in[0];
      end
      if (reg_wr_in && hit_pol) begin
        pol_ff <= reg_wdata_in[TERM_N-1:0];
      end
      // Read data stands only in the cycle after the strobe
      rdata_ff <= reg_rd_in ? rd_value : 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // ---------------- Step divider ----------------
  assign tick = (tick_cnt_ff == TICK_W'(TICK_CYC - 1));

  // Free-running 0.1 s enable; delays are therefore accurate to one step
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick ? '0 : tick_cnt_ff + TICK_W'(1);
    end
  end

  // ---------------- Sequencer cycle pulse ----------------
  wire seq_done_rise = sequencer_cycle_done_in & ~seq_done_d_ff;

  assign cycle_pulse = (pulse_cnt_ff != '0);

  // fixed-width pulse timer; a new cycle restarts the full width
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seq_done_d_ff <= 1'b0;
      pulse_cnt_ff  <= '0;
    end else begin
      seq_done_d_ff <= sequencer_cycle_done_in;
      if (seq_done_rise) begin
        pulse_cnt_ff <= PULSE_W'(PULSE_CYC);
      end else if (cycle_pulse) begin
        pulse_cnt_ff <= pulse_cnt_ff - PULSE_W'(1);
      end
    end
  end

  // ---------------- Condition table ----------------
  // code zero has no function
  assign cond[0]  = 1'b0;
  assign cond[1]  = freq_reached_in;
  assign cond[2]  = freq_level_detect_one_in;
  assign cond[3]  = fault_stop_in;
  assign cond[4]  = motor_overload_warn_in;
  assign cond[5]  = drive_overload_accum_in && (drive_overload_left_in <= OVL_LEAD_STEP);
  assign cond[6]  = running_in && output_freq_zero_in;
  // zero speed, held on when stopped
  assign cond[7]  = output_freq_zero_in || !running_in;
  assign cond[8]  = at_upper_limit_in;
  // lower limit, forced off when stopped
  assign cond[9]  = running_in && at_lower_limit_in;
  assign cond[10] = count_set_reached_in;
  assign cond[11] = count_desig_reached_in;
  assign cond[12] = (length_actual_in > length_setpoint_in);
  assign cond[13] = cycle_pulse;
  assign cond[14] = (run_time_in > run_time_limit_in);
  assign cond[15] = set_freq_beyond_in && (at_upper_limit_in || at_lower_limit_in);
  assign cond[16] = speed_mode_in && torque_at_limit_in && stall_protect_in;
  assign cond[17] = circuits_stable_in && !fault_stop_in && ready_in;
  assign cond[18] = running_in;
  assign cond[19] = (first_analog_input_in > second_analog_input_in);
  assign cond[20] = undervoltage_in;
  // reserved and unimplemented codes up to 36 stay off
  assign cond[36:21] = '0;
  // Lower limit reached, held on while stopped
  assign cond[37] = at_lower_limit_in || !running_in;
  assign cond[40:38] = '0;

  // ---------------- Per-terminal logic ----------------
  genvar t;
  generate
    for (t = 0; t < TERM_N; t++) begin : g_term
      logic [DATA_W-1:0] code;                     // This terminal's code
      logic              in_range;                 // Code within table
      logic              enabled;                  // Terminal allowed to switch
      logic              wr_fn;                    // Code register write
      logic              wr_dly;                   // Delay register write
      logic              settled;                  // Never short of the set delay

      assign code     = fn_ff[t];
      assign in_range = (code <= CODE_MAX);
      // switch function only in switch mode
      assign enabled  = (t != int'(TERM_SWITCH)) || (hs_mode_ff == HS_MODE_SWITCH);
      assign raw[t]   = enabled && in_range && cond[code[5:0]];
      assign wr_fn    = reg_wr_in && hit_fn && (fn_idx == 2'(t));
      assign wr_dly   = reg_wr_in && hit_dly && (dly_idx == 2'(t));
      assign settled  = (dly_ff[t] == '0) || (hold_cnt_ff[t] > dly_ff[t]);

      // Code and delay registers
      always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
          fn_ff[t]  <= (t == int'(TERM_RELAY_ONE)) ? RST_RELAY1_FN :
                       (t == int'(TERM_COLLECTOR)) ? RST_COLL_FN   :
                       (t == int'(TERM_RELAY_TWO)) ? RST_RELAY2_FN : RST_SWITCH_FN;
          dly_ff[t] <= RST_DELAY;
        end else begin
          if (wr_fn) begin
            fn_ff[t] <= reg_wdata_in;
          end
          if (wr_dly) begin
            dly_ff[t] <= dly_wval;
          end
        end
      end

      // Delay stage; a change that reverts before settling is dropped
      always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
          state_ff[t]    <= 1'b0;
          hold_cnt_ff[t] <= '0;
        end else if (raw[t] == state_ff[t]) begin
          // No pending change
          hold_cnt_ff[t] <= '0;
        end else if (settled) begin
          state_ff[t]    <= raw[t];
          hold_cnt_ff[t] <= '0;
        end else if (tick) begin
          hold_cnt_ff[t] <= hold_cnt_ff[t] + 16'h0001;
        end
      end

      always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pin_ff[t] <= 1'b0;
        end else begin
          pin_ff[t] <= state_ff[t] ^ pol_ff[t];
        end
      end
    end
  endgenerate

  // ---------------- Outputs ----------------
  // Pulse-frequency scaling sits elsewhere; this only flags the mode
  assign pulse_output_mode_out = (hs_mode_ff == HS_MODE_PULSE);
  assign switch_output_out     = pin_ff[TERM_SWITCH];
  assign relay_one_out         = pin_ff[TERM_RELAY_ONE];
  assign relay_two_out         = pin_ff[TERM_RELAY_TWO];
  assign collector_output_out  = pin_ff[TERM_COLLECTOR];

endmodule

// *** shared/output_select_pkg.sv ***
// Constants and types shared by the output terminal function selector
package output_select_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ         = 100_000_000;

  // Register port geometry
  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned TERM_N         = 4;

  // Register offsets (word index on the register port)
  localparam logic [3:0]  OFF_HS_MODE    = 4'h0;
  localparam logic [3:0]  OFF_FN_BASE    = 4'h1;  // Switch, relay one, relay two, collector
  localparam logic [3:0]  OFF_POLARITY   = 4'h5;
  localparam logic [3:0]  OFF_DELAY_BASE = 4'h6;  // Four delay registers follow
  localparam logic [3:0]  OFF_STATUS     = 4'hA;

  // Reset values
  localparam logic [15:0] RST_HS_MODE    = 16'h0000;
  localparam logic [15:0] RST_SWITCH_FN  = 16'h0000;
  localparam logic [15:0] RST_RELAY1_FN  = 16'h0002;
  localparam logic [15:0] RST_RELAY2_FN  = 16'h0000;
  localparam logic [15:0] RST_COLL_FN    = 16'h0001;
  localparam logic [15:0] RST_POLARITY   = 16'h0000;
  localparam logic [15:0] RST_DELAY      = 16'h0000;

  // High-speed terminal mode values
  localparam logic        HS_MODE_PULSE  = 1'b0;
  localparam logic        HS_MODE_SWITCH = 1'b1;

  // Selection code range and field layout
  localparam logic [15:0] CODE_MAX       = 16'h0028;  // Forty
  localparam int unsigned CODE_N         = 41;

  // Output delay: 0.1 s steps, at most 3600.0 s
  localparam int unsigned STEP_MS        = 100;
  localparam int unsigned DELAY_MAX_S    = 3600;
  localparam logic [15:0] DELAY_MAX_STEP = 16'(DELAY_MAX_S * 1000 / STEP_MS);
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * STEP_MS;

  // Sequencer cycle-complete pulse width
  localparam int unsigned PULSE_MS       = 250;
  localparam int unsigned PULSE_CYCLES   = CLK_HZ / 1000 * PULSE_MS;

  // Drive overload pre-warning lead, in delay steps
  localparam int unsigned OVL_LEAD_S     = 10;
  localparam logic [15:0] OVL_LEAD_STEP  = 16'(OVL_LEAD_S * 1000 / STEP_MS);

  // Terminal index, also the polarity digit position
  typedef enum logic [1:0] {
    TERM_SWITCH    = 2'b00,
    TERM_RELAY_ONE = 2'b01,
    TERM_RELAY_TWO = 2'b10,
    TERM_COLLECTOR = 2'b11
  } term_t;

endpackage

// *** verification/load_wiring_model.sv ***
// Relay coil and pulled-up open-collector load seen from the terminals
`timescale 1ns/1ps

module load_wiring_model #(
  parameter int unsigned PICKUP = 2            // Relay pick-up in cycles, 0 answers at once
) (
  input  wire logic clock_in,                  // System clock
  input  wire logic relay_one_in,              // Relay one coil drive
  input  wire logic collector_in,              // Transistor base drive
  output logic      relay_one_closed_out,      // Contact state after pick-up
  output logic      load_line_out              // Pulled-up load line
);
  logic [7:0] hist_ff;                         // Past coil drives, newest first
  wire  [8:0] chain = {hist_ff, relay_one_in};
  // A real contact closes late, so the bench cannot lean on instant answers
  always_ff @(posedge clock_in) begin
    hist_ff <= {hist_ff[6:0], relay_one_in};
  end
  assign relay_one_closed_out = chain[PICKUP];
  // A conducting transistor sinks the pull-up to common
  assign load_line_out = ~collector_in;
endmodule

// *** verification/select_checker_assertions.sv ***
// Concurrent checks on the output terminal selector ports
`timescale 1ns/1ps

module select_checker
  import output_select_pkg::*;
(
  input wire logic              clock_in,
  input wire logic              nrst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic              running_in,
  input wire logic              fault_stop_in,
  input wire logic              output_freq_zero_in,
  input wire logic              undervoltage_in,
  input wire logic              pulse_output_mode_out,
  input wire logic              switch_output_out,
  input wire logic              relay_one_out,
  input wire logic              relay_two_out,
  input wire logic              collector_output_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  logic [15:0] code_ff [4];  // Shadow selection codes
  logic [3:0]  pol_ff;       // Shadow polarity digits
  logic [3:0]  dly0_ff;      // Delay register holds zero
  logic        mode_ff;      // Shadow high-speed mode
  logic [1:0]  age_ff;       // Cycles since any write, saturating
  wire         fn_wr  = reg_wr_in && reg_addr_in >= OFF_FN_BASE && reg_addr_in < OFF_POLARITY;
  wire         dly_wr = reg_wr_in && reg_addr_in >= OFF_DELAY_BASE && reg_addr_in < OFF_STATUS;
  // Pins lag the configuration by two stages, so checks wait for settling
  wire         settled = (age_ff == 2'h3);

  // Rebuild the configuration from the write strobes
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      code_ff <= '{16'h0000, 16'h0002, 16'h0000, 16'h0001};
      pol_ff  <= 4'h0;
      dly0_ff <= 4'hF;
      mode_ff <= 1'b0;
      age_ff  <= 2'h0;
    end else begin
      if (fn_wr) code_ff[2'(reg_addr_in - OFF_FN_BASE)] <= reg_wdata_in;
      if (dly_wr) dly0_ff[2'(reg_addr_in - OFF_DELAY_BASE)] <= (reg_wdata_in == 16'h0000);
      if (reg_wr_in && reg_addr_in == OFF_POLARITY) pol_ff <= reg_wdata_in[3:0];
      if (reg_wr_in && reg_addr_in == OFF_HS_MODE) mode_ff <= reg_wdata_in[0];
      age_ff <= reg_wr_in ? 2'h0 : (settled ? age_ff : age_ff + 2'h1);
    end
  end

  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data not zero outside the answer cycle");
  readback_code_a: assert property (reg_rd_in && reg_addr_in == 4'h2 |=>
    reg_rdata_out == code_ff[1]) else $error("relay one code read back wrong");
  mode_pin_a: assert property (pulse_output_mode_out == !mode_ff)
    else $error("pulse mode pin disagrees with mode register");
  switch_idle_a: assert property (settled && !mode_ff && dly0_ff[0] |->
    switch_output_out == pol_ff[0]) else $error("switch pin active in pulse mode");
  zero_code_a: assert property (settled && dly0_ff[2] && code_ff[2] == 16'h0000 |->
    relay_two_out == pol_ff[2]) else $error("relay two active with code zero");
  fault_sel_a: assert property (settled && dly0_ff[2] && code_ff[2] == 16'h0003 |->
    relay_two_out == ($past(fault_stop_in, 2) ^ pol_ff[2])) else $error("fault pin wrong");
  undervolt_sel_a: assert property (settled && dly0_ff[3] && code_ff[3] == 16'h0014 |->
    collector_output_out == ($past(undervoltage_in, 2) ^ pol_ff[3]))
    else $error("undervoltage pin wrong");
  reserved_code_a: assert property (settled && dly0_ff[1] &&
    code_ff[1] inside {[16'h0015:16'h0024]} |-> relay_one_out == pol_ff[1])
    else $error("relay one active on a reserved code");
  zero_stop_a: assert property (settled && dly0_ff[1] && code_ff[1] == 16'h0007 |->
    relay_one_out == (($past(output_freq_zero_in, 2) || !$past(running_in, 2)) ^ pol_ff[1]))
    else $error("zero speed pin wrong");

  cover property (reg_rd_in && reg_addr_in == 4'h2);
  cover property (settled && code_ff[2] == 16'h0003 && relay_two_out);
  cover property ($rose(relay_one_out));
endmodule

bind output_terminal_function_select select_checker u_chk (
  .clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .running_in(running_in), .fault_stop_in(fault_stop_in),
  .output_freq_zero_in(output_freq_zero_in), .undervoltage_in(undervoltage_in),
  .pulse_output_mode_out(pulse_output_mode_out), .switch_output_out(switch_output_out),
  .relay_one_out(relay_one_out), .relay_two_out(relay_two_out),
  .collector_output_out(collector_output_out));

// *** verification/test_output_terminal_function_select.sv ***
// Self-checking bench for the output terminal function selector
`timescale 1ns/1ps

module test_output_terminal_function_select
  import output_select_pkg::*;
;
  localparam int unsigned TICK  = 10;          // Short step keeps delay runs brief
  localparam int unsigned PULSE = 20;          // Short sequencer pulse
  logic              clock_in, nrst_in, reg_wr_in, reg_rd_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, d;
  logic [18:0]       flags;                    // One-bit status inputs
  logic [15:0]       vals [7];                 // Numeric status inputs
  logic              pulse_mode, sw_pin, r1_pin, r2_pin, oc_pin, line_lvl, e;
  logic [3:0]        pol;                      // Polarity digits in use
  logic [15:0]       rst_tab [5] = '{16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0001};
  int                errors = 0, comparisons = 0, cycles = 0, n;

  output_terminal_function_select #(.TICK_CYC(TICK), .PULSE_CYC(PULSE)) DUT (
    .clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .running_in(flags[0]), .fault_stop_in(flags[1]),
    .freq_reached_in(flags[2]), .freq_level_detect_one_in(flags[3]),
    .motor_overload_warn_in(flags[4]), .drive_overload_accum_in(flags[5]),
    .drive_overload_left_in(vals[0]), .output_freq_zero_in(flags[6]),
    .at_upper_limit_in(flags[7]), .at_lower_limit_in(flags[8]), .set_freq_beyond_in(flags[9]),
    .count_set_reached_in(flags[10]), .count_desig_reached_in(flags[11]),
    .length_actual_in(vals[1]), .length_setpoint_in(vals[2]),
    .sequencer_cycle_done_in(flags[12]), .run_time_in(vals[3]), .run_time_limit_in(vals[4]),
    .speed_mode_in(flags[13]), .torque_at_limit_in(flags[14]), .stall_protect_in(flags[15]),
    .circuits_stable_in(flags[16]), .ready_in(flags[17]), .first_analog_input_in(vals[5]),
    .second_analog_input_in(vals[6]), .undervoltage_in(flags[18]),
    .pulse_output_mode_out(pulse_mode), .switch_output_out(sw_pin), .relay_one_out(r1_pin),
    .relay_two_out(r2_pin), .collector_output_out(oc_pin));

  load_wiring_model #(.PICKUP(2)) u_load (.clock_in(clock_in), .relay_one_in(r1_pin),
    .collector_in(oc_pin), .relay_one_closed_out(), .load_line_out(line_lvl));

  // Expected condition for a code, from the current status inputs
  function automatic logic exp_cond(input int c);
    case (c)
      1: return flags[2];
      2: return flags[3];
      3: return flags[1];
      4: return flags[4];
      5: return flags[5] && vals[0] <= 16'h0064;
      6: return flags[0] && flags[6];
      7: return flags[6] || !flags[0];
      8: return flags[7];
      9: return flags[0] && flags[8];
      10: return flags[10];
      11: return flags[11];
      12: return vals[1] > vals[2];
      14: return vals[3] > vals[4];
      15: return flags[9] && (flags[7] || flags[8]);
      16: return flags[13] && flags[14] && flags[15];
      17: return flags[16] && flags[17] && !flags[1];
      18: return flags[0];
      19: return vals[5] > vals[6];
      20: return flags[18];
      37: return flags[8] || !flags[0];
      default: return 1'b0;
    endcase
  endfunction

  // Register write, one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in    <= 1'b0;
  endtask

  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
    #1 v = reg_rdata_out;
  endtask

  // Random status, sequencer line kept low, then let the pins settle
  task automatic stir();
    @(posedge clock_in);
    flags <= 19'($urandom) & 19'h7EFFF;
    foreach (vals[i]) vals[i] <= 16'($urandom_range(0, 200));
    repeat (3) @(posedge clock_in);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // Hang guard, generous against the expected 1300 or so cycles
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    nrst_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    flags = '0;
    foreach (vals[i]) vals[i] = 16'h0000;
    n = $urandom(11454);
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(4'(i), d);
      check("reset value", rst_tab[i], d);
    end
    rd(4'hB, d);
    check("unmapped read", 16'h0000, d);
    for (int i = 1; i < 5; i++) begin
      n = $urandom_range(0, 40);
      wr(4'(i), 16'(n));
      rd(4'(i), d);
      check("code readback", 16'(n), d);
    end
    $display("test registers done");
    wr(OFF_HS_MODE, 16'h0001);
    #1 check("pulse mode pin", 16'h0000, pulse_mode);
    // Same code on all four terminals, random polarity and status
    for (int c = 0; c <= 40; c++) begin
      for (int t = 0; t < 4; t++) wr(OFF_FN_BASE + 4'(t), 16'(c));
      for (int k = 0; k < 3; k++) begin
        pol = 4'($urandom);
        wr(OFF_POLARITY, {12'h000, pol});
        stir();
        e = exp_cond(c);
        check("switch pin", e ^ pol[0], sw_pin);
        check("relay one pin", e ^ pol[1], r1_pin);
        check("relay two pin", e ^ pol[2], r2_pin);
        check("collector pin", e ^ pol[3], oc_pin);
        check("load line", !oc_pin, line_lvl);
      end
    end
    wr(OFF_HS_MODE, 16'h0000);
    stir();
    check("switch in pulse mode", pol[0], sw_pin);
    check("pulse mode pin", 16'h0001, pulse_mode);
    $display("test function table done");
    wr(OFF_POLARITY, 16'h0000);
    wr(OFF_FN_BASE + 4'h1, 16'h000D);
    @(posedge clock_in);
    flags[12] <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clock_in);
      flags[12] <= 1'b0;
      #1 if (r1_pin === 1'b1) n++;
    end
    check("pulse width", 16'(PULSE), 16'(n));
    $display("test sequencer pulse done");
    wr(OFF_DELAY_BASE + 4'h1, 16'hFFFF);
    rd(OFF_DELAY_BASE + 4'h1, d);
    check("delay clamp", 16'h8CA0, d);
    wr(OFF_DELAY_BASE + 4'h1, 16'h0003);
    wr(OFF_FN_BASE + 4'h1, 16'h0014);
    @(posedge clock_in);
    flags[18] <= 1'b0;
    repeat (60) @(posedge clock_in);
    flags[18] <= 1'b1;
    n = 0;
    while (r1_pin !== 1'b1 && n < 80) begin
      @(posedge clock_in);
      #1 n++;
    end
    check("delay window", 16'h0001, 16'(n >= 29 && n <= 44));
    $display("test output delay done");
    close_out();
  end
endmodule
